// File: verilog/qrc_pkg.sv
// Constants and field layout for the slave port QoS regulation registers
`default_nettype none

package qrc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_SLV = 5;
    localparam int NUM_LITE = 3;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 7;

    ////////////////////////////////////////////////////////////////////////
    // Address map: slave index in [6:4], register select in [3:2]
    localparam int SLV_LSB = 4;
    localparam int SEL_LSB = 2;
    localparam logic [1:0] REG_WQOS = 2'h0;
    localparam logic [1:0] REG_CTRL = 2'h1;
    localparam logic [1:0] REG_OTLIM = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int WQOS_OVR_LSB = 0;
    localparam int WQOS_CUR_LSB = 8;
    localparam int CTRL_WQV_BIT = 0;
    localparam int CTRL_RQV_BIT = 1;
    localparam int CTRL_WOT_BIT = 2;
    localparam int CTRL_ROT_BIT = 3;
    localparam int CTRL_WMODE_BIT = 16;
    localparam int CTRL_RMODE_BIT = 20;
    localparam int CTRL_QHIGH_BIT = 21;
    localparam int OT_W_FRAC_LSB = 0;
    localparam int OT_W_INT_LSB = 8;
    localparam int OT_R_FRAC_LSB = 16;
    localparam int OT_R_INT_LSB = 24;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [3:0] WQOS_OVR_RST = 4'h0;
    localparam logic CTRL_BIT_RST = 1'b0;
    localparam logic [5:0] OT_INT_RST = 6'h00;
    localparam logic [7:0] OT_FRAC_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Built-in outstanding maxima
    localparam logic [CNT_W-1:0] RD_HW_MAX = 7'h10;
    localparam logic [CNT_W-1:0] WR_HW_MAX = 7'h10;

endpackage

`default_nettype wire

// File: verilog/qrc_ot_if.sv
// Interface between register block and one outstanding regulator channel
`timescale 1ns/1ps
`default_nettype none

interface qrc_ot_if;
    import qrc_pkg::*;
    logic en;
    logic [5:0] int_lim;
    logic [7:0] frac_lim;
    logic [CNT_W-1:0] hw_max;
    logic accept;
    logic retire;
    logic allow;

    modport ctrl (
        output en,
        output int_lim,
        output frac_lim,
        output hw_max,
        output accept,
        output retire,
        input allow
    );

    modport chan (
        input en,
        input int_lim,
        input frac_lim,
        input hw_max,
        input accept,
        input retire,
        output allow
    );
endinterface

`default_nettype wire

// File: verilog/qrc_ot_chan.sv
// Outstanding transaction regulator for one address channel
`timescale 1ns/1ps
`default_nettype none

module qrc_ot_chan
    import qrc_pkg::*;
(
    input wire logic MCLK,
    input wire logic SRST,
    qrc_ot_if.chan ot
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [7:0] acc_q;
    logic [8:0] acc_sum;
    logic en_q;
    logic allow_q;
    logic [CNT_W-1:0] prog_lim;
    logic [CNT_W-1:0] lim;

    ////////////////////////////////////////////////////////////////////////
    // Outstanding count
    always_comb begin
        cnt_d = cnt_q;
        if (ot.accept && !ot.retire) begin
            cnt_d = cnt_q + 7'h01;
        end else if (ot.retire && !ot.accept && cnt_q != 7'h00) begin
            cnt_d = cnt_q - 7'h01;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            cnt_q <= 7'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable taken over only while nothing is outstanding
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            en_q <= CTRL_BIT_RST;
        end else if (cnt_q == 7'h00 && !ot.accept) begin
            en_q <= ot.en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fraction accumulator: carry grants one extra slot
    assign acc_sum = {1'b0, acc_q} + {1'b0, ot.frac_lim};

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            acc_q <= 8'h00;
        end else begin
            acc_q <= acc_sum[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective limit
    assign prog_lim = {1'b0, ot.int_lim} + {6'h00, acc_sum[8]};

    always_comb begin
        lim = ot.hw_max;
        if (en_q && (ot.int_lim != 6'h00 || ot.frac_lim != 8'h00)) begin
            if (prog_lim < ot.hw_max) begin
                lim = prog_lim;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            allow_q <= 1'b0;
        end else begin
            allow_q <= (cnt_d < lim);
        end
    end

    assign ot.allow = allow_q;

endmodule

`default_nettype wire

// File: verilog/qrc_slave_port_regs.sv
// Slave port QoS regulation registers, write QoS override and limits
`timescale 1ns/1ps
`default_nettype none

module qrc_slave_port_regs
    import qrc_pkg::*;
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic REG_SECURE,
    input wire logic SECURE_ACCESS_EN,
    output logic [31:0] RDATA,
    input wire logic [NUM_SLV-1:0] QOS_OVERRIDE_SELECT,
    input wire logic [NUM_SLV-1:0][3:0] AWQOS_IN,
    input wire logic [NUM_SLV-1:0][3:0] WQV_CURRENT,
    output logic [NUM_SLV-1:0][3:0] AWQOS_OUT,
    output logic [NUM_SLV-1:0] WR_QV_EN,
    output logic [NUM_SLV-1:0] RD_QV_EN,
    output logic [NUM_SLV-1:0] WR_PERIOD_MODE,
    output logic [NUM_SLV-1:0] RD_PERIOD_MODE,
    output logic [NUM_SLV-1:0] QUIESCE_HIGH,
    input wire logic [NUM_LITE-1:0] AW_ACCEPT,
    input wire logic [NUM_LITE-1:0] B_RETIRE,
    input wire logic [NUM_LITE-1:0] AR_ACCEPT,
    input wire logic [NUM_LITE-1:0] R_RETIRE,
    output logic [NUM_LITE-1:0] AW_ALLOW,
    output logic [NUM_LITE-1:0] AR_ALLOW
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input int s,
                                     input logic [1:0] r);
        logic ok;
        ok = (a[7] == 1'b0) && (a[1:0] == 2'h0);
        ok = ok && (a[SLV_LSB+2:SLV_LSB] == 3'(s));
        ok = ok && (a[SEL_LSB+1:SEL_LSB] == r);
        return ok;
    endfunction

    logic acc_ok;
    logic wr_ok;
    logic rd_ok;

    assign acc_ok = REG_SECURE || SECURE_ACCESS_EN;
    assign wr_ok = WR && acc_ok;
    assign rd_ok = RD && acc_ok;

    ////////////////////////////////////////////////////////////////////////
    // Override select pin synchroniser
    logic [NUM_SLV-1:0] ovr_meta_q;
    logic [NUM_SLV-1:0] ovr_q;

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ovr_meta_q <= '0;
            ovr_q <= '0;
        end else begin
            ovr_meta_q <= QOS_OVERRIDE_SELECT;
            ovr_q <= ovr_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per slave registers
    logic [NUM_SLV-1:0][3:0] wovr_q;
    logic [NUM_SLV-1:0] wqv_en_q;
    logic [NUM_SLV-1:0] rqv_en_q;
    logic [NUM_SLV-1:0] wot_en_q;
    logic [NUM_SLV-1:0] rot_en_q;
    logic [NUM_SLV-1:0] wmode_q;
    logic [NUM_SLV-1:0] rmode_q;
    logic [NUM_SLV-1:0] qhigh_q;
    logic [NUM_SLV-1:0][3:0] awqos_q;

    genvar gs;
    generate
        for (gs = 0; gs < NUM_SLV; gs++) begin : g_slv

            // Write QoS override value
            always_ff @(posedge MCLK) begin
                if (SRST) begin
                    wovr_q[gs] <= WQOS_OVR_RST;
                end else if (wr_ok && reg_hit(ADDR, gs, REG_WQOS)) begin
                    wovr_q[gs] <= WDATA[WQOS_OVR_LSB+3:WQOS_OVR_LSB];
                end
            end

            // Value regulator enables and modes
            always_ff @(posedge MCLK) begin
                if (SRST) begin
                    wqv_en_q[gs] <= CTRL_BIT_RST;
                    rqv_en_q[gs] <= CTRL_BIT_RST;
                    wmode_q[gs] <= CTRL_BIT_RST;
                    rmode_q[gs] <= CTRL_BIT_RST;
                    qhigh_q[gs] <= CTRL_BIT_RST;
                end else if (wr_ok && reg_hit(ADDR, gs, REG_CTRL)) begin
                    wqv_en_q[gs] <= WDATA[CTRL_WQV_BIT];
                    rqv_en_q[gs] <= WDATA[CTRL_RQV_BIT];
                    wmode_q[gs] <= WDATA[CTRL_WMODE_BIT];
                    rmode_q[gs] <= WDATA[CTRL_RMODE_BIT];
                    qhigh_q[gs] <= WDATA[CTRL_QHIGH_BIT];
                end
            end

            // Outstanding enables exist on lite ports only
            if (gs < NUM_LITE) begin : g_lite_en
                always_ff @(posedge MCLK) begin
                    if (SRST) begin
                        wot_en_q[gs] <= CTRL_BIT_RST;
                        rot_en_q[gs] <= CTRL_BIT_RST;
                    end else if (wr_ok && reg_hit(ADDR, gs, REG_CTRL)) begin
                        wot_en_q[gs] <= WDATA[CTRL_WOT_BIT];
                        rot_en_q[gs] <= WDATA[CTRL_ROT_BIT];
                    end
                end
            end else begin : g_full_en
                always_ff @(posedge MCLK) begin
                    wot_en_q[gs] <= 1'b0;
                    rot_en_q[gs] <= 1'b0;
                end
            end

            // Write QoS selection
            always_ff @(posedge MCLK) begin
                if (SRST) begin
                    awqos_q[gs] <= 4'h0;
                end else if (ovr_q[gs] && !wqv_en_q[gs]) begin
                    awqos_q[gs] <= wovr_q[gs];
                end else if (ovr_q[gs] && AWQOS_IN[gs] == 4'h0) begin
                    awqos_q[gs] <= WQV_CURRENT[gs];
                end else begin
                    awqos_q[gs] <= AWQOS_IN[gs];
                end
            end
        end
    endgenerate

    assign AWQOS_OUT = awqos_q;
    assign WR_QV_EN = wqv_en_q;
    assign RD_QV_EN = rqv_en_q;
    assign WR_PERIOD_MODE = wmode_q;
    assign RD_PERIOD_MODE = rmode_q;
    assign QUIESCE_HIGH = qhigh_q;

    ////////////////////////////////////////////////////////////////////////
    // Outstanding limits and regulators, lite ports only
    logic [NUM_LITE-1:0][5:0] r_int_q;
    logic [NUM_LITE-1:0][7:0] r_frac_q;
    logic [NUM_LITE-1:0][5:0] w_int_q;
    logic [NUM_LITE-1:0][7:0] w_frac_q;

    genvar gl;
    generate
        for (gl = 0; gl < NUM_LITE; gl++) begin : g_ot
            qrc_ot_if aw_if ();
            qrc_ot_if ar_if ();

            always_ff @(posedge MCLK) begin
                if (SRST) begin
                    r_int_q[gl] <= OT_INT_RST;
                    r_frac_q[gl] <= OT_FRAC_RST;
                    w_int_q[gl] <= OT_INT_RST;
                    w_frac_q[gl] <= OT_FRAC_RST;
                end else if (wr_ok && reg_hit(ADDR, gl, REG_OTLIM)) begin
                    r_int_q[gl] <= WDATA[OT_R_INT_LSB+5:OT_R_INT_LSB];
                    r_frac_q[gl] <= WDATA[OT_R_FRAC_LSB+7:OT_R_FRAC_LSB];
                    w_int_q[gl] <= WDATA[OT_W_INT_LSB+5:OT_W_INT_LSB];
                    w_frac_q[gl] <= WDATA[OT_W_FRAC_LSB+7:OT_W_FRAC_LSB];
                end
            end

            assign aw_if.en = wot_en_q[gl];
            assign aw_if.int_lim = w_int_q[gl];
            assign aw_if.frac_lim = w_frac_q[gl];
            assign aw_if.hw_max = WR_HW_MAX;
            assign aw_if.accept = AW_ACCEPT[gl];
            assign aw_if.retire = B_RETIRE[gl];
            assign AW_ALLOW[gl] = aw_if.allow;

            assign ar_if.en = rot_en_q[gl];
            assign ar_if.int_lim = r_int_q[gl];
            assign ar_if.frac_lim = r_frac_q[gl];
            assign ar_if.hw_max = RD_HW_MAX;
            assign ar_if.accept = AR_ACCEPT[gl];
            assign ar_if.retire = R_RETIRE[gl];
            assign AR_ALLOW[gl] = ar_if.allow;

            qrc_ot_chan u_aw (
                .MCLK(MCLK),
                .SRST(SRST),
                .ot(aw_if.chan)
            );

            qrc_ot_chan u_ar (
                .MCLK(MCLK),
                .SRST(SRST),
                .ot(ar_if.chan)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read back
    logic [31:0] rd_d;
    logic [31:0] rdata_q;

    always_comb begin
        rd_d = 32'h0000_0000;
        for (int s = 0; s < NUM_SLV; s++) begin
            if (reg_hit(ADDR, s, REG_WQOS)) begin
                rd_d[WQOS_OVR_LSB+3:WQOS_OVR_LSB] = wovr_q[s];
                if (ovr_q[s] && wqv_en_q[s]) begin
                    rd_d[WQOS_CUR_LSB+3:WQOS_CUR_LSB] = WQV_CURRENT[s];
                end
            end
            if (reg_hit(ADDR, s, REG_CTRL)) begin
                rd_d[CTRL_WQV_BIT] = wqv_en_q[s];
                rd_d[CTRL_RQV_BIT] = rqv_en_q[s];
                rd_d[CTRL_WOT_BIT] = wot_en_q[s];
                rd_d[CTRL_ROT_BIT] = rot_en_q[s];
                rd_d[CTRL_WMODE_BIT] = wmode_q[s];
                rd_d[CTRL_RMODE_BIT] = rmode_q[s];
                rd_d[CTRL_QHIGH_BIT] = qhigh_q[s];
            end
        end
        for (int l = 0; l < NUM_LITE; l++) begin
            if (reg_hit(ADDR, l, REG_OTLIM)) begin
                rd_d[OT_R_INT_LSB+5:OT_R_INT_LSB] = r_int_q[l];
                rd_d[OT_R_FRAC_LSB+7:OT_R_FRAC_LSB] = r_frac_q[l];
                rd_d[OT_W_INT_LSB+5:OT_W_INT_LSB] = w_int_q[l];
                rd_d[OT_W_FRAC_LSB+7:OT_W_FRAC_LSB] = w_frac_q[l];
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_ok) begin
            rdata_q <= rd_d;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign RDATA = rdata_q;

endmodule

`default_nettype wire

// File: dv/qrc_master_model.sv
// Behavioural lite masters facing the outstanding regulators
`timescale 1ns/1ps
`default_nettype none
module qrc_master_model
    import qrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [NUM_LITE-1:0] want,
    input wire logic hold,
    input wire logic [NUM_LITE-1:0] allow,
    output logic [NUM_LITE-1:0] accept,
    output logic [NUM_LITE-1:0] retire
);
    logic [NUM_LITE-1:0][CNT_W-1:0] cnt_q;

    // Address handed over only while allowed
    assign accept = want & allow;
    // One response a cycle unless held back
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            retire <= '0;
        end else begin
            for (int i = 0; i < NUM_LITE; i++) begin
                cnt_q[i] <= cnt_q[i] + CNT_W'(accept[i]) - CNT_W'(retire[i]);
                retire[i] <= !hold &&
                    (cnt_q[i] + CNT_W'(accept[i]) > CNT_W'(retire[i]));
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/qrc_regs_assertions.sv
// Port checker for the slave port QoS regulation registers
`timescale 1ns/1ps
`default_nettype none
module qrc_regs_assertions
    import qrc_pkg::*;
(
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic REG_SECURE,
    input wire logic SECURE_ACCESS_EN,
    input wire logic [31:0] RDATA,
    input wire logic [NUM_SLV-1:0] QOS_OVERRIDE_SELECT,
    input wire logic [NUM_SLV-1:0][3:0] AWQOS_IN,
    input wire logic [NUM_SLV-1:0][3:0] WQV_CURRENT,
    input wire logic [NUM_SLV-1:0][3:0] AWQOS_OUT,
    input wire logic [NUM_SLV-1:0] WR_QV_EN,
    input wire logic [NUM_SLV-1:0] RD_QV_EN,
    input wire logic [NUM_SLV-1:0] WR_PERIOD_MODE,
    input wire logic [NUM_SLV-1:0] RD_PERIOD_MODE,
    input wire logic [NUM_SLV-1:0] QUIESCE_HIGH,
    input wire logic [NUM_LITE-1:0] AW_ACCEPT,
    input wire logic [NUM_LITE-1:0] B_RETIRE,
    input wire logic [NUM_LITE-1:0] AW_ALLOW,
    input wire logic [NUM_LITE-1:0] AR_ALLOW
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SRST);

    logic [CNT_W-1:0] ot_q;
    logic ok_acc;
    assign ok_acc = REG_SECURE || SECURE_ACCESS_EN;
    // Outstanding writes on lite port 0
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ot_q <= '0;
        end else begin
            ot_q <= ot_q + CNT_W'(AW_ACCEPT[0])
                - CNT_W'(B_RETIRE[0] && ot_q != '0);
        end
    end
    ////////////////////////////////////////////////////////////////////
    sequence sel_on;
        QOS_OVERRIDE_SELECT[0] [*4];
    endsequence
    sequence sel_off;
        !QOS_OVERRIDE_SELECT[0] [*4];
    endsequence

    a_reset_clears_out: assert property (disable iff (1'b0) SRST |=>
        AW_ALLOW == '0 && AR_ALLOW == '0 && AWQOS_OUT == '0)
        else $error("outputs not cleared by reset");
    a_allow_after_reset: assert property ($fell(SRST) |=>
        &AW_ALLOW && &AR_ALLOW) else $error("allow low after reset");
    a_hw_max_bound: assert property (ot_q >= WR_HW_MAX |->
        !AW_ALLOW[0] && ot_q == WR_HW_MAX) else $error("hw max exceeded");
    a_qos_regulated: assert property (sel_on ##1 (QOS_OVERRIDE_SELECT[0]
        && WR_QV_EN[0] && AWQOS_IN[0] == 4'h0) |=>
        AWQOS_OUT[0] == $past(WQV_CURRENT[0])) else $error("qos live bad");
    a_qos_pass: assert property (sel_off ##1 !QOS_OVERRIDE_SELECT[0] |=>
        AWQOS_OUT[0] == $past(AWQOS_IN[0])) else $error("qos pass bad");
    a_ctrl_write: assert property (WR && ADDR == 8'h04 && ok_acc |=>
        WR_QV_EN[0] == $past(WDATA[0])) else $error("ctrl write lost");
    a_ctrl_modes: assert property (WR && ADDR == 8'h14 && ok_acc |=>
        {QUIESCE_HIGH[1], RD_PERIOD_MODE[1], WR_PERIOD_MODE[1], RD_QV_EN[1]}
        == $past({WDATA[21], WDATA[20], WDATA[16], WDATA[1]}))
        else $error("mode bits wrong");
    a_refuse_write: assert property (WR && !ok_acc |=>
        $stable(WR_QV_EN)) else $error("non-secure write took");
    a_refuse_read: assert property (RD && !ok_acc |=>
        RDATA == 32'h0) else $error("non-secure read data");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside slot");
endmodule

bind qrc_slave_port_regs qrc_regs_assertions u_chk (
    .MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .REG_SECURE(REG_SECURE), .SECURE_ACCESS_EN(SECURE_ACCESS_EN),
    .RDATA(RDATA), .QOS_OVERRIDE_SELECT(QOS_OVERRIDE_SELECT),
    .AWQOS_IN(AWQOS_IN), .WQV_CURRENT(WQV_CURRENT), .AWQOS_OUT(AWQOS_OUT),
    .WR_QV_EN(WR_QV_EN), .RD_QV_EN(RD_QV_EN),
    .WR_PERIOD_MODE(WR_PERIOD_MODE), .RD_PERIOD_MODE(RD_PERIOD_MODE),
    .QUIESCE_HIGH(QUIESCE_HIGH), .AW_ACCEPT(AW_ACCEPT),
    .B_RETIRE(B_RETIRE), .AW_ALLOW(AW_ALLOW), .AR_ALLOW(AR_ALLOW));
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the slave port QoS regulation registers
`timescale 1ns/1ps
`default_nettype none
module testbench
    import qrc_pkg::*;
;
    logic MCLK, SRST, WR, RD, REG_SECURE, SECURE_ACCESS_EN, hold;
    logic [7:0] ADDR;
    logic [31:0] WDATA, RDATA;
    logic [NUM_SLV-1:0] QOS_OVERRIDE_SELECT, WR_QV_EN, RD_QV_EN;
    logic [NUM_SLV-1:0] WR_PERIOD_MODE, RD_PERIOD_MODE, QUIESCE_HIGH;
    logic [NUM_SLV-1:0][3:0] AWQOS_IN, WQV_CURRENT, AWQOS_OUT;
    logic [NUM_LITE-1:0] want, AW_ACCEPT, B_RETIRE, AR_ACCEPT, R_RETIRE;
    logic [NUM_LITE-1:0] AW_ALLOW, AR_ALLOW;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;

    qrc_slave_port_regs dut (
        .MCLK(MCLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .REG_SECURE(REG_SECURE),
        .SECURE_ACCESS_EN(SECURE_ACCESS_EN), .RDATA(RDATA),
        .QOS_OVERRIDE_SELECT(QOS_OVERRIDE_SELECT), .AWQOS_IN(AWQOS_IN),
        .WQV_CURRENT(WQV_CURRENT), .AWQOS_OUT(AWQOS_OUT),
        .WR_QV_EN(WR_QV_EN), .RD_QV_EN(RD_QV_EN),
        .WR_PERIOD_MODE(WR_PERIOD_MODE), .RD_PERIOD_MODE(RD_PERIOD_MODE),
        .QUIESCE_HIGH(QUIESCE_HIGH), .AW_ACCEPT(AW_ACCEPT),
        .B_RETIRE(B_RETIRE), .AR_ACCEPT(AR_ACCEPT), .R_RETIRE(R_RETIRE),
        .AW_ALLOW(AW_ALLOW), .AR_ALLOW(AR_ALLOW));
    qrc_master_model aw_m (.clk(MCLK), .rst(SRST), .want(want),
        .hold(hold), .allow(AW_ALLOW), .accept(AW_ACCEPT), .retire(B_RETIRE));
    qrc_master_model ar_m (.clk(MCLK), .rst(SRST), .want(want),
        .hold(hold), .allow(AR_ALLOW), .accept(AR_ACCEPT), .retire(R_RETIRE));

    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("FAIL %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
        @(posedge MCLK);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 chk("rdata", RDATA, e);
        @(posedge MCLK);
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rc(8'h00, 32'h0);
        rc(8'h04, 32'h0);
        rc(8'h08, 32'h0);
        wr(8'h28, 32'h3fff3fff);
        wr(8'h38, 32'h3fff3fff);
        rc(8'h28, 32'h3fff3fff);
        rc(8'h38, 32'h0);
        rc(8'h01, 32'h0);
        chk("allow", 32'({AW_ALLOW, AR_ALLOW}), 32'h3f);
    endtask
    task automatic t_ctrl();
        for (int s = 0; s < NUM_SLV; s++) begin
            wr(8'(s * 16 + 4), 32'hffffffff);
            rc(8'(s * 16 + 4), s < 3 ? 32'h0031000f : 32'h00310003);
            chk("ctl", 32'({QUIESCE_HIGH[s], RD_PERIOD_MODE[s],
                WR_PERIOD_MODE[s], RD_QV_EN[s], WR_QV_EN[s]}), 32'h1f);
            wr(8'(s * 16 + 4), 32'h0);
        end
        chk("ctl0", 32'({QUIESCE_HIGH, RD_PERIOD_MODE, WR_PERIOD_MODE,
            RD_QV_EN, WR_QV_EN}), 32'h0);
    endtask
    task automatic t_qos();
        for (int s = 0; s < NUM_SLV; s++) begin
            wr(8'(s * 16), 32'hfffffff0 | (s + 5));
            rc(8'(s * 16), 32'(s + 5));
        end
        QOS_OVERRIDE_SELECT <= '1;
        AWQOS_IN <= {NUM_SLV{4'h3}};
        WQV_CURRENT <= {NUM_SLV{4'h9}};
        repeat (6) @(posedge MCLK);
        for (int s = 0; s < NUM_SLV; s++) begin
            chk("awqos", 32'(AWQOS_OUT[s]), 32'(s + 5));
            wr(8'(s * 16 + 4), 32'h1);
        end
        AWQOS_IN <= '0;
        repeat (3) @(posedge MCLK);
        for (int s = 0; s < NUM_SLV; s++) begin
            chk("awqos", 32'(AWQOS_OUT[s]), 32'h9);
            rc(8'(s * 16), 32'(s + 32'h905));
        end
        AWQOS_IN <= {NUM_SLV{4'h3}};
        repeat (3) @(posedge MCLK);
        chk("awqos", 32'(AWQOS_OUT), 32'(20'h33333));
        QOS_OVERRIDE_SELECT <= '0;
        for (int s = 0; s < NUM_SLV; s++) wr(8'(s * 16 + 4), 32'h0);
    endtask
    task automatic t_sec();
        REG_SECURE <= 1'b0;
        wr(8'h04, 32'h1);
        chk("sec", 32'(WR_QV_EN[0]), 32'h0);
        rc(8'h00, 32'h0);
        SECURE_ACCESS_EN <= 1'b1;
        wr(8'h04, 32'h1);
        rc(8'h04, 32'h1);
        wr(8'h04, 32'h0);
        REG_SECURE <= 1'b1;
        SECURE_ACCESS_EN <= 1'b0;
    endtask
    task automatic burst(input logic keep, output int na, nr);
        na = 0;
        nr = 0;
        want <= 3'h1;
        hold <= 1'b1;
        repeat (24) begin
            #1 na += AW_ACCEPT[0];
            nr += AR_ACCEPT[0];
            @(posedge MCLK);
        end
        want <= 3'h0;
        hold <= keep;
        if (!keep) repeat (20) @(posedge MCLK);
    endtask
    task automatic ot(input logic [31:0] lim, input int ea, er);
        int na;
        int nr;
        wr(8'h08, lim);
        wr(8'h04, 32'hc);
        rc(8'h08, lim);
        burst(1'b0, na, nr);
        chk("aw_ot", na, ea);
        chk("ar_ot", nr, er);
    endtask
    task automatic t_defer();
        int na;
        int nr;
        wr(8'h08, 32'h01000100);
        burst(1'b1, na, nr);
        wr(8'h04, 32'h0);
        burst(1'b1, na, nr);
        chk("ot_defer", na + nr, 0);
        @(posedge MCLK);
        hold <= 1'b0;
        repeat (8) @(posedge MCLK);
        burst(1'b0, na, nr);
        chk("ot_off", na + nr, 32);
    endtask

    initial begin
        SRST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        REG_SECURE = 1'b1;
        SECURE_ACCESS_EN = 1'b0;
        hold = 1'b0;
        want = '0;
        ADDR = '0;
        WDATA = '0;
        QOS_OVERRIDE_SELECT = '0;
        AWQOS_IN = '0;
        WQV_CURRENT = '0;
        repeat (3) @(posedge MCLK);
        SRST <= 1'b0;
        @(posedge MCLK);
        t_reset();
        t_ctrl();
        t_qos();
        t_sec();
        ot(32'h02000100, 1, 2);
        ot(32'h0, 16, 16);
        ot(32'h3f003f00, 16, 16);
        ot(32'h00800080, 1, 1);
        t_defer();
        end_of_test();
    end
endmodule
`default_nettype wire
